// ---- hdl/irc_context.sv ----
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Cycle-match start waits for equal cycle number
// - Hardware clears cycle-match enable once active
// - Multichannel accepts every channel in masks
// - Otherwise accept only the match channel
// - Reserved control bits read as zero
// - Run starts, cleared run stops processing
// - Run changes only by software or reset
// - Wake resumes (here only stored for readback, drives nothing); cleared on every descriptor fetch
// - Dead set on fatal error while active, cleared with run
// - Active high while processing descriptors
// - Speed code 000/001/010 for 100/200/400
// - Event code written after input command completes
// - Buffer-fill packs packets back to back
// - Header-keep stores header, else stripped
// - Control via separate set and clear images
module irc_context
(
	input  wire logic              i_mclk,
	input  wire logic              i_rstn,
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	input  wire logic              i_cycle_start,
	input  wire logic [12:0]       i_bus_cycle_number,
	input  wire irc_pkg::irc_pkt_t i_pkt,
	input  wire logic              i_desc_fetch,
	input  wire logic              i_desc_busy,
	input  wire irc_pkg::irc_cmpl_t i_cmpl,
	input  wire logic              i_fatal,
	output logic                   o_pkt_accept,
	output logic                   o_process,
	output logic                   o_pack_buffers_back_to_back,
	output logic                   o_keep_packet_header
);

	irc_pkg::irc_regs_t r;
	irc_pkg::irc_regs_t next_r;

	function automatic logic mask_hit(input logic [63:0] m,
		input logic [5:0] ch);
		mask_hit = m[ch];
	endfunction

	function automatic logic reg_wr_hit(input logic wr,
		input logic [7:0] a, input logic [7:0] target);
		reg_wr_hit = wr && (a == target);
	endfunction

	function automatic logic [31:0] ctrl_word(input irc_pkg::irc_regs_t s);
		logic [31:0] w;
		w = irc_pkg::WORD_ZERO;
		w[irc_pkg::BIT_FILL]   = s.pack_buffers_back_to_back;
		w[irc_pkg::BIT_HDR]    = s.keep_packet_header;
		w[irc_pkg::BIT_CYCEN]  = s.start_on_cycle_enable;
		w[irc_pkg::BIT_MULTI]  = s.multi_channel_mode;
		w[irc_pkg::BIT_RUN]    = s.run;
		w[irc_pkg::BIT_WAKE]   = s.wake;
		w[irc_pkg::BIT_DEAD]   = s.dead;
		w[irc_pkg::BIT_ACTIVE] = s.busy;
		w[irc_pkg::SPD_LSB +: 3] = s.spd;
		w[irc_pkg::EVT_LSB +: 5] = s.evt;
		ctrl_word = w;
	endfunction

	logic set_wr;
	logic clr_wr;
	logic chan_ok;
	logic cyc_hit;

	assign set_wr = reg_wr_hit(i_wr, i_addr,
		irc_pkg::ADDR_CTRL_SET);
	assign clr_wr = reg_wr_hit(i_wr, i_addr,
		irc_pkg::ADDR_CTRL_CLR);
	assign cyc_hit = i_cycle_start &&
		(i_bus_cycle_number == r.start_cycle_compare_value);

	always_comb
	begin
		if (r.multi_channel_mode)
			chan_ok = mask_hit({r.mask_hi, r.mask_lo}, i_pkt.channel);
		else
			chan_ok = (i_pkt.channel == r.match_channel);
	end

	// Packets only land while descriptors are being processed
	assign o_pkt_accept = i_pkt.valid && chan_ok && r.busy && !r.dead;
	assign o_process = r.busy && !r.dead;
	assign o_rdata = r.rdata;
	assign o_pack_buffers_back_to_back = r.pack_buffers_back_to_back;
	assign o_keep_packet_header = r.keep_packet_header;

	always_comb
	begin
		logic [31:0] s;
		logic [31:0] c;
		s = set_wr ? i_wdata : irc_pkg::WORD_ZERO;
		c = clr_wr ? i_wdata : irc_pkg::WORD_ZERO;
		next_r = r;
		// Set and clear images; zero bits leave the field alone
		if (s[irc_pkg::BIT_FILL])  next_r.pack_buffers_back_to_back = 1'b1;
		if (c[irc_pkg::BIT_FILL])  next_r.pack_buffers_back_to_back = 1'b0;
		if (s[irc_pkg::BIT_HDR])   next_r.keep_packet_header = 1'b1;
		if (c[irc_pkg::BIT_HDR])   next_r.keep_packet_header = 1'b0;
		if (s[irc_pkg::BIT_CYCEN]) next_r.start_on_cycle_enable = 1'b1;
		if (c[irc_pkg::BIT_CYCEN]) next_r.start_on_cycle_enable = 1'b0;
		if (s[irc_pkg::BIT_MULTI]) next_r.multi_channel_mode = 1'b1;
		if (c[irc_pkg::BIT_MULTI]) next_r.multi_channel_mode = 1'b0;
		if (s[irc_pkg::BIT_RUN])   next_r.run = 1'b1;
		if (c[irc_pkg::BIT_RUN])   next_r.run = 1'b0;
		if (s[irc_pkg::BIT_WAKE])  next_r.wake = 1'b1;
		if (c[irc_pkg::BIT_WAKE])  next_r.wake = 1'b0;
		// A fetch in the cycle of a wake write consumes that wake
		if (i_desc_fetch)
			next_r.wake = 1'b0;
		// Dead follows run down; a fatal error in the same cycle wins
		if (!next_r.run)
			next_r.dead = 1'b0;
		if (i_fatal && r.busy)
			next_r.dead = 1'b1;
		if (i_cmpl.done && r.busy)
			next_r.evt = i_cmpl.event_code;
		if (o_pkt_accept)
			next_r.spd = i_pkt.speed;
		if (reg_wr_hit(i_wr, i_addr, irc_pkg::ADDR_MATCH))
		begin
			next_r.start_cycle_compare_value = i_wdata[irc_pkg::CYC_LSB +: 13];
			next_r.match_channel = i_wdata[irc_pkg::CHAN_LSB +: 6];
		end
		if (reg_wr_hit(i_wr, i_addr, irc_pkg::ADDR_CHAN_MASK_HI))
			next_r.mask_hi = i_wdata;
		if (reg_wr_hit(i_wr, i_addr, irc_pkg::ADDR_CHAN_MASK_LO))
			next_r.mask_lo = i_wdata;
		case (r.state)
			irc_pkg::IRC_IDLE:
			begin
				next_r.busy = 1'b0;
				if (r.run && !r.dead)
				begin
					if (r.start_on_cycle_enable)
						next_r.state = irc_pkg::IRC_WAIT;
					else
						next_r.state = irc_pkg::IRC_RUN;
				end
			end
			irc_pkg::IRC_WAIT:
			begin
				if (!r.run)
					next_r.state = irc_pkg::IRC_IDLE;
				else if (!r.start_on_cycle_enable || cyc_hit)
				begin
					next_r.state = irc_pkg::IRC_RUN;
					next_r.busy = 1'b1;
					next_r.start_on_cycle_enable = 1'b0;
				end
			end
			irc_pkg::IRC_RUN:
			begin
				next_r.busy = 1'b1;
				if (!r.run && !i_desc_busy)
				begin
					next_r.state = irc_pkg::IRC_IDLE;
					next_r.busy = 1'b0;
				end
			end
			default:
			begin
				next_r.state = irc_pkg::IRC_IDLE;
				next_r.busy = 1'b0;
			end
		endcase
		if (i_rd)
		begin
			case (i_addr)
				irc_pkg::ADDR_CTRL_SET,
				irc_pkg::ADDR_CTRL_CLR: next_r.rdata = ctrl_word(r);
				irc_pkg::ADDR_MATCH:
				begin
					next_r.rdata = irc_pkg::WORD_ZERO;
					next_r.rdata[irc_pkg::CYC_LSB +: 13] =
						r.start_cycle_compare_value;
					next_r.rdata[irc_pkg::CHAN_LSB +: 6] = r.match_channel;
				end
				irc_pkg::ADDR_CHAN_MASK_HI: next_r.rdata = r.mask_hi;
				irc_pkg::ADDR_CHAN_MASK_LO: next_r.rdata = r.mask_lo;
				default: next_r.rdata = irc_pkg::WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			r <= '0;
			r.state <= irc_pkg::IRC_IDLE;
		end
		else
			r <= next_r;
	end

	a_cycen_cleared: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		$rose(r.busy) |-> !r.start_on_cycle_enable)
		else $error("cycle-match enable not cleared on start");

	a_cyc_start: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(r.state == irc_pkg::IRC_WAIT && r.start_on_cycle_enable && r.run
		&& !cyc_hit) |=> !r.busy)
		else $error("context started without cycle match");

	a_wait_entry: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(r.state == irc_pkg::IRC_IDLE && r.run && !r.dead
		&& r.start_on_cycle_enable) |=> r.state == irc_pkg::IRC_WAIT)
		else $error("cycle-match start did not wait");

	a_match_start: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(r.state == irc_pkg::IRC_WAIT && r.run && cyc_hit) |=>
		(r.busy && r.state == irc_pkg::IRC_RUN))
		else $error("context not started on cycle match");

	a_run_hold: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(!set_wr && !clr_wr) |=> $stable(r.run))
		else $error("run changed without a write");

	a_run_set: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(set_wr && i_wdata[irc_pkg::BIT_RUN]) |=> r.run)
		else $error("run not set through set image");

	a_run_clr: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(clr_wr && i_wdata[irc_pkg::BIT_RUN]) |=> !r.run)
		else $error("run not cleared through clear image");

	a_fill_set: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(set_wr && i_wdata[irc_pkg::BIT_FILL]) |=>
		r.pack_buffers_back_to_back)
		else $error("fill bit not set through set image");

	a_fill_clr: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(clr_wr && i_wdata[irc_pkg::BIT_FILL]) |=>
		!r.pack_buffers_back_to_back)
		else $error("fill bit not cleared through clear image");

	a_cycen_clr: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(clr_wr && i_wdata[irc_pkg::BIT_CYCEN]) |=>
		!r.start_on_cycle_enable)
		else $error("cycle-match enable not cleared by image");

	a_opts_hold: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(!set_wr && !clr_wr) |=> ($stable(r.pack_buffers_back_to_back)
		&& $stable(r.keep_packet_header)
		&& $stable(r.multi_channel_mode)))
		else $error("option bit changed without a write");

	a_wake_fetch: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_desc_fetch |=> !r.wake)
		else $error("wake not cleared on fetch");

	a_wake_set: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(set_wr && i_wdata[irc_pkg::BIT_WAKE] && !i_desc_fetch) |=>
		r.wake)
		else $error("wake not set through set image");

	a_dead_set: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_fatal && r.busy) |=> r.dead ##0 !o_process)
		else $error("dead not set on fatal error");

	a_dead_clr: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(!r.run && !i_fatal) |=> !r.dead)
		else $error("dead survives cleared run");

	a_dead_hold: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(r.dead && r.run && !clr_wr) |=> r.dead)
		else $error("dead dropped while run still set");

	a_busy_in_run: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		r.busy |-> r.state == irc_pkg::IRC_RUN)
		else $error("active outside the running state");

	a_run_active: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(r.state == irc_pkg::IRC_RUN && (r.run || i_desc_busy)) |=>
		r.busy)
		else $error("active low while processing");

	a_reserved_zero: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_rd && i_addr == irc_pkg::ADDR_CTRL_SET) |=>
		(o_rdata & irc_pkg::CTRL_RSVD_MASK) == irc_pkg::WORD_ZERO)
		else $error("reserved control bits not zero");

	a_reserved_clr: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_rd && i_addr == irc_pkg::ADDR_CTRL_CLR) |=>
		(o_rdata & irc_pkg::CTRL_RSVD_MASK) == irc_pkg::WORD_ZERO)
		else $error("reserved bits not zero in clear image");

	a_single_chan: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(o_pkt_accept && !r.multi_channel_mode) |->
		i_pkt.channel == r.match_channel)
		else $error("packet accepted on wrong channel");

	a_multi_chan: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(o_pkt_accept && r.multi_channel_mode) |->
		mask_hit({r.mask_hi, r.mask_lo}, i_pkt.channel))
		else $error("multichannel accepted unmasked channel");

	a_spd_latch: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		o_pkt_accept |=> r.spd == $past(i_pkt.speed))
		else $error("speed of accepted packet not recorded");

	a_evt_write: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_cmpl.done && r.busy) |=>
		r.evt == $past(i_cmpl.event_code))
		else $error("event code not recorded");

	a_evt_hold: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		!(i_cmpl.done && r.busy) |=> $stable(r.evt))
		else $error("event code changed without completion");

	a_active_drop: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		(r.state == irc_pkg::IRC_RUN && !r.run && !i_desc_busy) |=>
		!r.busy)
		else $error("active stuck after stop");

endmodule // irc_context

// ---- hdl/irc_pkg.sv ----
package irc_pkg;

	// Register bus word addresses (byte addresses, aligned words)
	localparam logic [7:0] ADDR_CTRL_SET   = 8'h00;
	localparam logic [7:0] ADDR_CTRL_CLR   = 8'h04;
	localparam logic [7:0] ADDR_MATCH      = 8'h08;
	localparam logic [7:0] ADDR_CHAN_MASK_HI = 8'h0c;
	localparam logic [7:0] ADDR_CHAN_MASK_LO = 8'h10;

	// Control register field positions
	localparam int BIT_FILL   = 31;
	localparam int BIT_HDR    = 30;
	localparam int BIT_CYCEN  = 29;
	localparam int BIT_MULTI  = 28;
	localparam int BIT_RUN    = 15;
	localparam int BIT_WAKE   = 12;
	localparam int BIT_DEAD   = 11;
	localparam int BIT_ACTIVE = 10;
	localparam int SPD_LSB    = 5;
	localparam int EVT_LSB    = 0;

	// Match register fields
	localparam int CYC_LSB   = 12;
	localparam int CHAN_LSB  = 0;

	localparam logic [2:0] SPD_100 = 3'h0;
	localparam logic [2:0] SPD_200 = 3'h1;
	localparam logic [2:0] SPD_400 = 3'h2;

	localparam logic [12:0] CYC_ZERO = 13'h0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// Reserved control word bits, always read back as zero
	localparam logic [31:0] CTRL_RSVD_MASK = 32'h0fff_6300;

	typedef enum logic [2:0] {
		IRC_IDLE  = 3'b001,
		IRC_WAIT  = 3'b010,
		IRC_RUN   = 3'b100
	} irc_state_t;

	typedef struct packed {
		logic        valid;
		logic [5:0]  channel;
		logic [2:0]  speed;
	} irc_pkt_t;

	typedef struct packed {
		logic        done;
		logic [4:0]  event_code;
	} irc_cmpl_t;

	typedef struct packed {
		irc_state_t  state;
		logic        pack_buffers_back_to_back;
		logic        keep_packet_header;
		logic        start_on_cycle_enable;
		logic        multi_channel_mode;
		logic        run;
		logic        wake;
		logic        dead;
		logic        busy;
		logic [2:0]  spd;
		logic [4:0]  evt;
		logic [12:0] start_cycle_compare_value;
		logic [5:0]  match_channel;
		logic [31:0] mask_hi;
		logic [31:0] mask_lo;
		logic [31:0] rdata;
	} irc_regs_t;

endpackage

// ---- verification/irc_link_model.sv ----
`timescale 1ns/1ps
// Stands in for the link and descriptor engine; pulses last one cycle
module irc_link_model
(
	input  wire logic          i_mclk,
	input  wire logic          i_pkt_accept,
	output logic               o_cycle_start,
	output logic [12:0]        o_bus_cycle_number,
	output irc_pkg::irc_pkt_t  o_pkt,
	output logic               o_desc_fetch,
	output logic               o_desc_busy,
	output irc_pkg::irc_cmpl_t o_cmpl,
	output logic               o_fatal
);
	initial
	begin
		o_cycle_start = 1'b0;
		o_bus_cycle_number = 13'h0000;
		o_pkt = '0;
		o_desc_fetch = 1'b0;
		o_desc_busy = 1'b0;
		o_cmpl = '0;
		o_fatal = 1'b0;
	end
	// Kind 0 cycle start, 1 packet, 2 fetch, 3 done, 4 fatal, 5 busy level
	task automatic ev(input int k, input logic [12:0] v, output logic acc);
		@(posedge i_mclk);
		o_cycle_start <= (k == 0);
		o_bus_cycle_number <= v;
		o_pkt <= {k == 1, v[8:0]};
		o_desc_fetch <= (k == 2);
		o_cmpl <= {k == 3, v[4:0]};
		o_fatal <= (k == 4);
		if (k == 5)
			o_desc_busy <= v[0];
		#1 acc = i_pkt_accept;
		@(posedge i_mclk);
		// Stale fields inverted so nothing can lean on a held value
		o_cycle_start <= 1'b0;
		o_bus_cycle_number <= ~v;
		o_pkt <= {1'b0, ~v[8:0]};
		o_desc_fetch <= 1'b0;
		o_cmpl <= {1'b0, ~v[4:0]};
		o_fatal <= 1'b0;
	endtask
endmodule // irc_link_model

// ---- verification/iso_receive_context_control_bench.sv ----
`timescale 1ns/1ps
module iso_receive_context_control_bench;
	logic               i_mclk;
	logic               i_rstn;
	logic [7:0]         i_addr;
	logic [31:0]        i_wdata;
	logic               i_wr;
	logic               i_rd;
	logic [31:0]        o_rdata;
	logic               cs, fe, bz, ft, acc, pr, fl, hd;
	logic [12:0]        cn;
	irc_pkg::irc_pkt_t  pk_w;
	irc_pkg::irc_cmpl_t cm_w;
	int                 n_errors = 0;
	int                 num_checks = 0;
	localparam logic [7:0] S = 8'h00;
	localparam logic [7:0] C = 8'h04;

	irc_context irc_context_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_cycle_start(cs), .i_bus_cycle_number(cn),
		.i_pkt(pk_w), .i_desc_fetch(fe), .i_desc_busy(bz), .i_cmpl(cm_w),
		.i_fatal(ft), .o_pkt_accept(acc), .o_process(pr),
		.o_pack_buffers_back_to_back(fl), .o_keep_packet_header(hd));
	irc_link_model irc_link_model_i (.i_mclk(i_mclk), .i_pkt_accept(acc),
		.o_cycle_start(cs), .o_bus_cycle_number(cn), .o_pkt(pk_w),
		.o_desc_fetch(fe), .o_desc_busy(bz), .o_cmpl(cm_w), .o_fatal(ft));

	initial
	begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 chk("rdata", e, o_rdata);
	endtask
	task automatic pk(input logic [5:0] c, input logic [2:0] s, input logic e);
		logic a;
		irc_link_model_i.ev(1, {4'h0, c, s}, a);
		chk("accept", {31'h0, e}, {31'h0, a});
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge i_mclk);
		n_errors++;
		test_done;
	end
	initial
	begin
		logic a;
		i_rstn = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0000_0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (12) @(posedge i_mclk);
		i_rstn <= 1'b1;
		rd(S, 32'h0000_0000);
		// Status and reserved bits written too; they must not stick
		wr(S, 32'hffff_7fff);
		rd(S, 32'hf000_1000);
		chk("fill", 32'h1, {31'h0, fl});
		chk("hdr", 32'h1, {31'h0, hd});
		wr(C, 32'h5000_0000);
		rd(C, 32'ha000_1000);
		chk("hdr", 32'h0, {31'h0, hd});
		irc_link_model_i.ev(2, 13'h0000, a);
		rd(S, 32'ha000_0000);
		wr(irc_pkg::ADDR_MATCH, {7'h00, 13'h1abc, 12'h005});
		// Options left alone from here while running
		wr(S, 32'h0000_8000);
		irc_link_model_i.ev(0, 13'h1abb, a);
		rd(S, 32'ha000_8000);
		irc_link_model_i.ev(0, 13'h1abc, a);
		repeat (2) @(posedge i_mclk);
		rd(S, 32'h8000_8400);
		for (int s = 0; s < 3; s++)
		begin
			pk(6'h05, s[2:0], 1'b1);
			rd(S, 32'h8000_8400 | (s << 5));
		end
		pk(6'h06, irc_pkg::SPD_100, 1'b0);
		irc_link_model_i.ev(3, 13'h0011, a);
		rd(S, 32'h8000_8451);
		irc_link_model_i.ev(4, 13'h0000, a);
		rd(S, 32'h8000_8c51);
		chk("process", 32'h0, {31'h0, pr});
		irc_link_model_i.ev(5, 13'h0001, a);
		wr(C, 32'h0000_8000);
		rd(S, 32'h8000_0451);
		irc_link_model_i.ev(5, 13'h0000, a);
		repeat (2) @(posedge i_mclk);
		rd(S, 32'h8000_0051);
		// Fill stays set beside multichannel; single context only
		wr(S, 32'h1000_0000);
		wr(irc_pkg::ADDR_CHAN_MASK_LO, 32'h0000_0200);
		wr(S, 32'h0000_8000);
		repeat (3) @(posedge i_mclk);
		pk(6'h09, irc_pkg::SPD_200, 1'b1);
		pk(6'h05, irc_pkg::SPD_200, 1'b0);
		chk("process", 32'h1, {31'h0, pr});
		rd(8'h20, 32'h0000_0000);
		@(posedge i_mclk);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		rd(S, 32'h0000_0000);
		chk("fill", 32'h0, {31'h0, fl});
		chk("hdr", 32'h0, {31'h0, hd});
		test_done;
	end
endmodule // iso_receive_context_control_bench
